// ### hw/mvp_pkg.sv
// constants and types for the meter value processing core
// assumes a 125 MHz system clock and a one-second tick derived inside the core
package mvp_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned HOLD_SEC = 2;
    localparam int unsigned CAL_SEC = 8;
    localparam int unsigned SEC_CYCLES = CLK_HZ;
    localparam int unsigned HOLD_CYCLES = HOLD_SEC * CLK_HZ;
    localparam int unsigned CAL_CYCLES = CAL_SEC * CLK_HZ;
    localparam logic signed [31:0] OFFSET_MAX = 32'sd19999;
    localparam logic signed [31:0] OFFSET_MIN = -32'sd19999;
    localparam logic [13:0] DELAY_MAX = 14'd9999;
    localparam logic [6:0] CODE_FACTORY = 7'd66;
    localparam logic [6:0] CODE_VERSION = 7'd50;
    localparam logic [6:0] CODE_CAL = 7'd48;
    localparam logic signed [31:0] RESET_INPUT_POINT_ONE = 32'sd0;
    localparam logic signed [31:0] RESET_DISPLAY_POINT_ONE = 32'sd0;
    localparam logic signed [31:0] RESET_INPUT_POINT_TWO = 32'sd10000;
    localparam logic signed [31:0] RESET_DISPLAY_POINT_TWO = 32'sd10000;
    localparam logic [1:0] FILT_SHIFT1 = 2'd2;
    typedef enum logic [3:0] {
        MVP_UF_NONE = 4'h0, MVP_UF_LOCK = 4'h1, MVP_UF_ZERO = 4'h2, MVP_UF_RESET = 4'h3,
        MVP_UF_HOLD = 4'h4, MVP_UF_DSEL = 4'h5, MVP_UF_PRINT = 4'h6, MVP_UF_PRST = 4'h7,
        MVP_UF_SP1 = 4'h8, MVP_UF_SP2 = 4'h9, MVP_UF_SP12 = 4'ha
    } mvp_ufunc_t;
    typedef enum logic [1:0] {
        MVP_AS_DSP = 2'h0, MVP_AS_HI = 2'h1, MVP_AS_LO = 2'h2, MVP_AS_HILO = 2'h3
    } mvp_assign_t;
    typedef enum logic [2:0] {
        MVP_SV_IDLE = 3'h0, MVP_SV_SHOWRST = 3'h1, MVP_SV_SHOWVER = 3'h2,
        MVP_SV_CALWAIT = 3'h3, MVP_SV_CALMENU = 3'h4, MVP_SV_CALPT = 3'h5,
        MVP_SV_CALBUSY = 3'h6
    } mvp_svc_t;
endpackage

// ### hw/mvp_capture.sv
// qualified min or max capture: replaces the stored value after a sustained excursion
// assumes sec_tick_in is a one-cycle pulse once per second on clk_sys_in
`timescale 1ns/100ps
`default_nettype none
module mvp_capture import mvp_pkg::*; #(
    parameter bit IS_MAX = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic sec_tick_in,
    input wire logic [13:0] delay_sec_in,
    input wire logic signed [31:0] value_in,
    input wire logic load_in,
    output logic signed [31:0] capt_out
);
    logic signed [31:0] capt_reg, capt_next;
    logic [13:0] secs_reg, secs_next;
    logic beyond;
    always_comb begin
        beyond = IS_MAX ? (value_in > capt_reg) : (value_in < capt_reg);
        capt_next = capt_reg;
        secs_next = secs_reg;
        if (load_in) begin
            capt_next = value_in;
            secs_next = '0;
        end else if (!enable_in || !beyond) begin
            secs_next = '0;
        end else if (secs_reg >= delay_sec_in) begin
            // continuous excursion for the full delay: take it
            capt_next = value_in;
            secs_next = '0;
        end else if (sec_tick_in) begin
            secs_next = secs_reg + 14'd1;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capt_reg <= '0;
            secs_reg <= '0;
        end else begin
            capt_reg <= capt_next;
            secs_reg <= secs_next;
        end
    end
    assign capt_out = capt_reg;

    a_capt_qual: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!$past(load_in) && $changed(capt_reg)) |-> $past(secs_reg) >= $past(delay_sec_in))
        else $error("capture changed before delay expired");
    a_capt_off: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        (!$past(enable_in) && !$past(load_in)) |-> $stable(capt_reg))
        else $error("capture moved while disabled");
    c_capt_take: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        enable_in && !load_in ##1 $changed(capt_reg));
endmodule // mvp_capture
`default_nettype wire

// ### hw/mvp_core.sv
// meter value processing: scaling, offset, filter, user input, capture, service codes
// assumes conv_valid_in pulses once per conversion and keys are debounced on this clock
`timescale 1ns/100ps
`default_nettype none
module mvp_core import mvp_pkg::*; #(
    parameter int unsigned SEC_CYC = SEC_CYCLES,
    parameter int unsigned HOLD_CYC = HOLD_CYCLES,
    parameter int unsigned CAL_CYC = CAL_CYCLES,
    parameter logic [7:0] VERSION = 8'h11 // arbitrary value
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic conv_valid_in,
    input wire logic signed [31:0] conv_value_in,
    input wire logic user_in_n_in,
    input wire logic key_adv_in,
    input wire logic key_clr_in,
    input wire logic [3:0] user_func_in,
    input wire logic [1:0] user_assign_in,
    input wire logic [1:0] filter_level_in,
    input wire logic live_sample_style_in,
    input wire logic [1:0] point_edit_in,
    input wire logic signed [31:0] input_point_one_in,
    input wire logic signed [31:0] display_point_one_in,
    input wire logic signed [31:0] input_point_two_in,
    input wire logic signed [31:0] display_point_two_in,
    input wire logic offset_wr_in,
    input wire logic signed [31:0] offset_wr_val_in,
    input wire logic zero_key_in,
    input wire logic max_capture_enable_in,
    input wire logic min_capture_enable_in,
    input wire logic [13:0] max_delay_in,
    input wire logic [13:0] min_delay_in,
    input wire logic [1:0] num_displays_in,
    input wire logic [6:0] svc_code_in,
    input wire logic svc_enter_in,
    output logic signed [31:0] display_out,
    output logic signed [31:0] shown_out,
    output logic signed [31:0] offset_out,
    output logic signed [31:0] max_out,
    output logic signed [31:0] min_out,
    output logic [1:0] disp_sel_out,
    output logic print_req_out,
    output logic sp1_reset_out,
    output logic sp2_reset_out,
    output logic factory_load_out,
    output logic [2:0] svc_state_out,
    output logic [6:0] code_prompt_out,
    output logic [7:0] version_out,
    output logic cal_busy_out,
    output logic [1:0] cal_range_out,
    output logic cal_point_out,
    output logic signed [31:0] pt_latch_out
);
    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_s1_reg, rst_n;
    logic usr_s1_reg, usr_s2_reg, usr_d_reg;
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            usr_s1_reg <= 1'b1;
            usr_s2_reg <= 1'b1;
            usr_d_reg <= 1'b0;
        end else begin
            usr_s1_reg <= user_in_n_in;
            usr_s2_reg <= usr_s1_reg;
            usr_d_reg <= !usr_s2_reg;
        end
    end
    logic usr_act, usr_edge;
    assign usr_act = !usr_s2_reg;
    assign usr_edge = usr_act && !usr_d_reg;
    mvp_ufunc_t ufn;
    assign ufn = mvp_ufunc_t'(user_func_in);
    // assignment is honoured only for the three functions that use it
    logic asg_ok;
    assign asg_ok = (ufn == MVP_UF_RESET) || (ufn == MVP_UF_HOLD) || (ufn == MVP_UF_PRST);
    // ------------------------------------------------------------
    // scaling and filter
    // ------------------------------------------------------------
    // a zero input span would divide by zero; the result is then the first display point
    logic signed [31:0] dx, scaled, raw, cand;
    logic signed [63:0] prod;
    always_comb begin
        dx = input_point_two_in - input_point_one_in;
        prod = 64'(conv_value_in - input_point_one_in)
            * 64'(display_point_two_in - display_point_one_in);
        if (dx == 0) begin
            scaled = display_point_one_in;
        end else begin
            scaled = 32'(prod / 64'(dx)) + display_point_one_in;
        end
    end
    logic signed [31:0] off_reg, off_next, filt_reg, filt_next;
    assign raw = scaled + off_reg;
    always_comb begin
        case (filter_level_in)
            2'd0: cand = raw;
            2'd1: cand = filt_reg + ((raw - filt_reg) >>> FILT_SHIFT1);
            2'd2: cand = filt_reg + ((raw - filt_reg) >>> (FILT_SHIFT1 + 2'd1));
            // widen before adding: two bits would wrap the shift of four back to zero
            default: cand = filt_reg + ((raw - filt_reg) >>> (3'(FILT_SHIFT1) + 3'd2));
        endcase
        filt_next = conv_valid_in ? cand : filt_reg;
    end
    // ------------------------------------------------------------
    // offset, hold, display select, setpoint and print strobes
    // ------------------------------------------------------------
    logic zero_req, hold_dsp;
    logic signed [31:0] zoff, shown_reg, shown_next;
    logic [1:0] sel_reg, sel_next;
    logic sp1_next, sp2_next, prn_next, sp1_reg, sp2_reg, prn_reg, prst_reg;
    logic sv_factory;
    assign zero_req = zero_key_in || (usr_edge && ufn == MVP_UF_ZERO);
    assign hold_dsp = usr_act && ufn == MVP_UF_HOLD && asg_ok
        && mvp_assign_t'(user_assign_in) == MVP_AS_DSP;
    always_comb begin
        zoff = off_reg - filt_reg;
        off_next = off_reg;
        if (sv_factory) begin
            off_next = '0;
        end else if (zero_req) begin
            off_next = (zoff > OFFSET_MAX) ? OFFSET_MAX
                : (zoff < OFFSET_MIN) ? OFFSET_MIN : zoff;
        end else if (offset_wr_in) begin
            off_next = (offset_wr_val_in > OFFSET_MAX) ? OFFSET_MAX
                : (offset_wr_val_in < OFFSET_MIN) ? OFFSET_MIN : offset_wr_val_in;
        end
        shown_next = hold_dsp ? shown_reg : filt_reg;
        sel_next = sel_reg;
        if (usr_edge && ufn == MVP_UF_DSEL) begin
            sel_next = (sel_reg >= num_displays_in) ? 2'd0 : sel_reg + 2'd1;
        end
        sp1_next = usr_edge && (ufn == MVP_UF_SP1 || ufn == MVP_UF_SP12);
        sp2_next = usr_edge && (ufn == MVP_UF_SP2 || ufn == MVP_UF_SP12);
        prn_next = usr_edge && (ufn == MVP_UF_PRINT || ufn == MVP_UF_PRST);
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            off_reg <= '0;
            filt_reg <= '0;
            shown_reg <= '0;
            sel_reg <= '0;
            sp1_reg <= 1'b0;
            sp2_reg <= 1'b0;
            prn_reg <= 1'b0;
            prst_reg <= 1'b0;
        end else begin
            off_reg <= off_next;
            filt_reg <= filt_next;
            shown_reg <= shown_next;
            sel_reg <= sel_next;
            sp1_reg <= sp1_next;
            sp2_reg <= sp2_next;
            prn_reg <= prn_next;
            prst_reg <= prn_reg && ufn == MVP_UF_PRST; // reset follows the print request
        end
    end
    // ------------------------------------------------------------
    // min and max capture
    // ------------------------------------------------------------
    logic [26:0] tick_reg, tick_next;
    logic sec_tick, ld_hi, ld_lo, rst_ev;
    assign sec_tick = (tick_reg == 27'(SEC_CYC - 1));
    assign tick_next = sec_tick ? '0 : tick_reg + 27'd1;
    assign rst_ev = (usr_edge && ufn == MVP_UF_RESET && asg_ok) || prst_reg;
    assign ld_hi = sv_factory || (rst_ev && user_assign_in[0]);
    assign ld_lo = sv_factory || (rst_ev && user_assign_in[1]);
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_next;
        end
    end
    mvp_capture #(.IS_MAX(1'b1)) u_max (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n), .enable_in(max_capture_enable_in),
        .sec_tick_in(sec_tick), .delay_sec_in(max_delay_in), .value_in(filt_reg),
        .load_in(ld_hi), .capt_out(max_out)
    );
    mvp_capture #(.IS_MAX(1'b0)) u_min (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n), .enable_in(min_capture_enable_in),
        .sec_tick_in(sec_tick), .delay_sec_in(min_delay_in), .value_in(filt_reg),
        .load_in(ld_lo), .capt_out(min_out)
    );
    // ------------------------------------------------------------
    // service codes, calibration and live-sample point latch
    // ------------------------------------------------------------
    mvp_svc_t sv_reg, sv_next;
    logic [30:0] cnt_reg, cnt_next;
    logic [6:0] code_reg, code_next;
    logic [1:0] rng_reg, rng_next;
    logic cpt_reg, cpt_next;
    logic signed [31:0] pt_reg, pt_next;
    assign sv_factory = (sv_reg == MVP_SV_SHOWRST) && (cnt_reg == '0);
    always_comb begin
        sv_next = sv_reg;
        cnt_next = cnt_reg + 31'd1;
        code_next = code_reg;
        rng_next = rng_reg;
        cpt_next = cpt_reg;
        pt_next = pt_reg;
        if (point_edit_in != 2'd0 && live_sample_style_in) begin
            // live input shown until advance latches it
            pt_next = key_adv_in ? pt_reg : conv_value_in;
        end
        case (sv_reg)
            MVP_SV_IDLE: begin
                cnt_next = '0;
                if (svc_enter_in) begin
                    code_next = svc_code_in;
                    if (svc_code_in == CODE_FACTORY) sv_next = MVP_SV_SHOWRST;
                    else if (svc_code_in == CODE_VERSION) sv_next = MVP_SV_SHOWVER;
                end else if (code_reg == CODE_CAL && key_adv_in) begin
                    sv_next = MVP_SV_CALWAIT;
                end
            end
            MVP_SV_SHOWRST, MVP_SV_SHOWVER: begin
                if (cnt_reg >= 31'(SEC_CYC - 1)) begin
                    sv_next = MVP_SV_IDLE;
                    code_next = '0;
                end
            end
            MVP_SV_CALWAIT: begin
                if (!key_adv_in) sv_next = MVP_SV_IDLE;
                else if (cnt_reg >= 31'(HOLD_CYC - 2)) begin
                    sv_next = MVP_SV_CALMENU;
                    rng_next = '0;
                end
            end
            MVP_SV_CALMENU: begin
                cnt_next = '0;
                cpt_next = 1'b0;
                if (key_clr_in) rng_next = (rng_reg == 2'd2) ? 2'd0 : rng_reg + 2'd1;
                else if (key_adv_in) sv_next = MVP_SV_CALPT;
            end
            MVP_SV_CALPT: begin
                cnt_next = '0;
                if (key_adv_in) sv_next = MVP_SV_CALBUSY;
            end
            default: begin
                if (cnt_reg >= 31'(CAL_CYC - 1)) begin
                    cpt_next = !cpt_reg;
                    sv_next = cpt_reg ? MVP_SV_CALMENU : MVP_SV_CALPT;
                end
            end
        endcase
    end
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sv_reg <= MVP_SV_IDLE;
            cnt_reg <= '0;
            code_reg <= '0;
            rng_reg <= '0;
            cpt_reg <= 1'b0;
            pt_reg <= '0;
        end else begin
            sv_reg <= sv_next;
            cnt_reg <= cnt_next;
            code_reg <= code_next;
            rng_reg <= rng_next;
            cpt_reg <= cpt_next;
            pt_reg <= pt_next;
        end
    end
    assign display_out = filt_reg;
    assign shown_out = shown_reg;
    assign offset_out = off_reg;
    assign disp_sel_out = sel_reg;
    assign print_req_out = prn_reg;
    assign sp1_reset_out = sp1_reg;
    assign sp2_reset_out = sp2_reg;
    assign factory_load_out = sv_factory;
    assign svc_state_out = sv_reg;
    assign code_prompt_out = code_reg;
    assign version_out = VERSION;
    assign cal_busy_out = (sv_reg == MVP_SV_CALBUSY);
    assign cal_range_out = rng_reg;
    assign cal_point_out = cpt_reg;
    assign pt_latch_out = pt_reg;

    a_off_range: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        off_reg <= OFFSET_MAX && off_reg >= OFFSET_MIN)
        else $error("offset out of range");
    a_filt_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        !conv_valid_in |=> $stable(filt_reg))
        else $error("filter moved without a conversion");
    a_filt_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (conv_valid_in && filter_level_in == 2'd0) |=> filt_reg == $past(raw))
        else $error("level 0 not passthrough");
    a_zero_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (usr_edge && ufn == MVP_UF_ZERO && !sv_factory && zoff <= OFFSET_MAX
         && zoff >= OFFSET_MIN) |=> off_reg == $past(off_reg) - $past(filt_reg))
        else $error("zero did not cancel reading");
    a_hold_dsp: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        hold_dsp |=> $stable(shown_reg))
        else $error("held display changed");
    a_prst_seq: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (usr_edge && ufn == MVP_UF_PRST) |=> print_req_out ##1 prst_reg)
        else $error("print and reset order wrong");
    a_sp_both: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (usr_edge && ufn == MVP_UF_SP12) |=> sp1_reset_out && sp2_reset_out)
        else $error("both setpoints not reset");
    a_code_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (sv_reg == MVP_SV_SHOWVER && sv_next == MVP_SV_IDLE) |=> code_reg == 7'h00)
        else $error("prompt not cleared");
    a_cal_entry: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        (sv_reg == MVP_SV_IDLE && sv_next == MVP_SV_CALWAIT) |-> code_reg == CODE_CAL)
        else $error("calibration without code 48");
    c_zero: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        usr_edge && ufn == MVP_UF_ZERO);
    c_factory: cover property (@(posedge clk_sys_in) disable iff (!rst_n) sv_factory);
    c_cal_busy: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        sv_reg == MVP_SV_CALPT ##1 sv_reg == MVP_SV_CALBUSY);
endmodule // mvp_core
`default_nettype wire

// ### tb/mvp_panel_model.sv
// front-panel operator and user-input contact for the processing core
// assumes the core samples keys and contact on clk_sys_in
`timescale 1ns/100ps
`default_nettype none
module mvp_panel_model (
    input wire logic clk_sys_in,
    output logic user_in_n_out,
    output logic key_adv_out,
    output logic key_clr_out
);
    // a released contact reads high through its pull-up
    initial begin
        user_in_n_out = 1'b1;
        key_adv_out = 1'b0;
        key_clr_out = 1'b0;
    end
    // which: 0 contact, 1 advance, 2 clear; held n cycles, then idle n cycles
    task automatic press(input int which, input int n);
        @(negedge clk_sys_in);
        if (which == 0) user_in_n_out = 1'b0;
        else if (which == 1) key_adv_out = 1'b1;
        else key_clr_out = 1'b1;
        repeat (n) @(negedge clk_sys_in);
        user_in_n_out = 1'b1;
        key_adv_out = 1'b0;
        key_clr_out = 1'b0;
        repeat (n) @(negedge clk_sys_in);
    endtask
endmodule // mvp_panel_model
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the meter value processing core
// assumes shortened second, hold and calibration counts set below
`timescale 1ns/100ps
`default_nettype none
module testbench import mvp_pkg::*;;
    localparam int SEC = 20;
    localparam logic [7:0] VER = 8'h5a; // arbitrary value
    logic clk_sys_in = 1'b0, arst_n_in = 1'b0, conv_valid_in = 1'b0, offset_wr_in = 1'b0;
    logic zero_key_in = 1'b0, svc_enter_in = 1'b0, live_sample_style_in = 1'b0;
    logic user_in_n_in, key_adv_in, key_clr_in, max_capture_enable_in = 1'b1;
    logic min_capture_enable_in = 1'b1, print_req_out, sp1_reset_out, sp2_reset_out;
    logic factory_load_out, cal_busy_out, cal_point_out, pend = 1'b0;
    logic signed [31:0] conv_value_in = '0, offset_wr_val_in = '0, display_out, shown_out;
    logic signed [31:0] offset_out, max_out, min_out, pt_latch_out;
    logic signed [31:0] input_point_one_in = 32'sd0, display_point_one_in = 32'sd100;
    logic signed [31:0] input_point_two_in = 32'sd1000, display_point_two_in = 32'sd2100;
    logic [3:0] user_func_in = 4'h0;
    logic [1:0] user_assign_in = 2'h1, filter_level_in = 2'h0, point_edit_in = 2'h0;
    logic [1:0] num_displays_in = 2'h2, disp_sel_out, cal_range_out;
    logic [13:0] max_delay_in = 14'h1, min_delay_in = 14'h0;
    logic [6:0] svc_code_in = 7'h0, code_prompt_out;
    logic [7:0] version_out;
    logic [2:0] svc_state_out;
    int failures = 0, n_compared = 0, x, y, last;
    logic [31:0] dq[$];
    logic [31:0] pq[$];

    mvp_core #(.SEC_CYC(SEC), .HOLD_CYC(2 * SEC), .CAL_CYC(8 * SEC), .VERSION(VER)) i_dut (.*);
    mvp_panel_model i_panel (.clk_sys_in(clk_sys_in), .user_in_n_out(user_in_n_in),
        .key_adv_out(key_adv_in), .key_clr_out(key_clr_in));

    initial forever #4 clk_sys_in = ~clk_sys_in;

    function automatic int scl(input int v);
        return 100 + 2 * v;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conv(input int v, input int e);
        @(negedge clk_sys_in);
        conv_valid_in = 1'b1;
        conv_value_in = v;
        dq.push_back(e);
        last = e;
        @(negedge clk_sys_in);
        conv_valid_in = 1'b0;
    endtask
    task automatic wr_off(input int v);
        @(negedge clk_sys_in);
        offset_wr_in = 1'b1;
        offset_wr_val_in = v;
        @(negedge clk_sys_in);
        offset_wr_in = 1'b0;
    endtask
    task automatic svc(input int c);
        svc_code_in = 7'(c);
        @(negedge clk_sys_in);
        svc_enter_in = 1'b1;
        @(negedge clk_sys_in);
        svc_enter_in = 1'b0;
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // -------------------------------------------------------------
    // watchers: the oldest note is matched to each result as it shows
    // -------------------------------------------------------------
    always @(posedge clk_sys_in) begin
        if (pend) cmp(display_out, dq.pop_front());
        if (print_req_out | sp1_reset_out | sp2_reset_out)
            cmp({print_req_out, sp1_reset_out, sp2_reset_out}, pq.pop_front());
        pend = conv_valid_in;
    end
    initial begin
        repeat (6000) @(posedge clk_sys_in);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h53c7));
        repeat (3) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        conv(500, 1100);
        conv(3000, 6100);
        repeat (5) @(negedge clk_sys_in);
        cmp(max_out, 0);
        repeat (45) @(negedge clk_sys_in);
        cmp(max_out, 6100);
        conv(-250, -400);
        repeat (4) @(negedge clk_sys_in);
        cmp(min_out, -400);
        live_sample_style_in = 1'b1;
        point_edit_in = 2'h1;
        i_panel.press(1, 2);
        cmp(pt_latch_out, -250);
        point_edit_in = 2'h0;
        for (int l = 1; l < 4; l++) begin
            x = $urandom_range(4000);
            y = $urandom_range(4000);
            filter_level_in = 2'h0;
            conv(x, scl(x));
            filter_level_in = 2'(l);
            conv(y, scl(x) + ((scl(y) - scl(x)) >>> (l + 1)));
        end
        filter_level_in = 2'h0;
        wr_off(30000);
        cmp(offset_out, 19999);
        wr_off(-7);
        conv(500, 1093);
        zero_key_in = 1'b1;
        @(negedge clk_sys_in);
        zero_key_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        cmp(offset_out, -1100);
        conv(500, 0);
        user_func_in = 4'h4;
        user_assign_in = 2'h0;
        fork
            i_panel.press(0, 16);
            begin
                repeat (8) @(negedge clk_sys_in);
                conv(800, 600);
                cmp(shown_out, 0);
            end
        join
        user_assign_in = 2'h1;
        for (int f = 5; f < 11; f++) begin
            user_func_in = 4'(f);
            if (f > 5) pq.push_back({29'h0, f < 8, f == 8 || f == 10, f > 8});
            i_panel.press(0, 6);
        end
        cmp(disp_sel_out, 1);
        cmp(max_out, 600);
        cmp(min_out, -400);
        user_func_in = 4'h3;
        user_assign_in = 2'h2;
        i_panel.press(0, 6);
        cmp(min_out, 600);
        svc(66);
        cmp(svc_state_out, MVP_SV_SHOWRST);
        repeat (SEC + 4) @(negedge clk_sys_in);
        cmp(offset_out, 0);
        cmp(code_prompt_out, 0);
        svc(50);
        cmp(svc_state_out, MVP_SV_SHOWVER);
        cmp(version_out, VER);
        repeat (SEC + 4) @(negedge clk_sys_in);
        cmp(svc_state_out, MVP_SV_IDLE);
        svc(48);
        i_panel.press(1, 2 * SEC);
        cmp(svc_state_out, MVP_SV_CALMENU);
        i_panel.press(2, 1);
        cmp(cal_range_out, 1);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
